/* bench/serial_irq_slave_tb.sv */
`timescale 1ns/100ps
module serial_irq_slave_tb;
  logic                clk_sys = 1'b0;
  logic                reset_n = 1'b0;
  sirq_pkg::sirq_bus_t bus = '0;
  logic [7:0]          rdata;
  logic [3:0]          uart_irq = 4'hF;
  logic                watchdog_source = 1'b1;
  logic                mgmt_sig = 1'b1;
  logic                go = 1'b0;
  logic [2:0]          start_lo = 3'h3;
  logic [1:0]          stop_lo = 2'h3;
  logic                line;
  sirq_pkg::sirq_pin_t sirq_pin;
  sirq_pkg::sirq_pin_t mgmt_pin;
  logic [15:0]         lo_seen;
  int                  cycles;
  int                  errs;
  int                  miscompares = 0;
  int                  checks_done = 0;
  int                  ticks = 0;
  int                  t0;

  always #12.5 clk_sys = ~clk_sys;

  sirq_slave sirq_slave_inst (
    .clk_sys(clk_sys), .reset_n(reset_n), .bus(bus), .rdata(rdata),
    .uart_irq(uart_irq), .watchdog_source(watchdog_source),
    .mgmt_interrupt_signal(mgmt_sig), .sirq_in(line),
    .sirq_pin(sirq_pin), .mgmt_interrupt_pin(mgmt_pin));

  sirq_host_model sirq_host_model_inst (
    .clk_sys(clk_sys), .reset_n(reset_n), .go(go), .start_lo(start_lo),
    .stop_lo(stop_lo), .dev(sirq_pin), .line(line), .lo_seen(lo_seen),
    .cycles(cycles), .errs(errs));

  task automatic print_verdict;
    if (miscompares == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict

  task automatic note(input logic ok, input logic [31:0] got, exp);
    checks_done++;
    if (!ok) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : note

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    note(got === exp, 32'(got), 32'(exp));
  endtask : chk8

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    note(got === exp, 32'(got), 32'(exp));
  endtask : chk16

  task automatic chk_pin(input logic [1:0] got, input logic [1:0] exp);
    note(got === exp, 32'(got), 32'(exp));
  endtask : chk_pin

  task automatic chk_n(input int got, input int exp);
    note(got == exp, got, exp);
  endtask : chk_n

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    bus <= '0;
  endtask : wr

  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    bus <= '0;
    #1 chk8(rdata, exp);
  endtask : rd

  task automatic wait_for(input int target);
    while (cycles < target) @(posedge clk_sys);
  endtask : wait_for

  task automatic host(input int n, input logic [15:0] exp);
    @(posedge clk_sys);
    go <= 1'b1;
    wait_for(cycles + n);
    go <= 1'b0;
    chk16(lo_seen, exp);
  endtask : host

  always @(posedge clk_sys) begin
    ticks++;
    if (ticks == 5000) begin
      miscompares++;
      print_verdict();
    end
  end

  initial begin
    repeat (20) @(posedge clk_sys);
    reset_n <= 1'b1;
    rd(sirq_pkg::ADDR_CFG, sirq_pkg::CFG_RESET);
    rd(sirq_pkg::ADDR_MAP_A, sirq_pkg::MAP_RESET);
    rd(sirq_pkg::ADDR_SMI_EN, sirq_pkg::SMI_RESET);
    rd(sirq_pkg::ADDR_STATUS, 8'h00);
    wr(3'h6, 8'hFF);
    rd(3'h6, 8'h00);
    wr(sirq_pkg::ADDR_MAP_A, 8'hD3);
    wr(sirq_pkg::ADDR_MAP_B, 8'hFD);
    wr(sirq_pkg::ADDR_MAP_W, 8'h05);
    wr(sirq_pkg::ADDR_SMI_EN, 8'hC0);
    rd(sirq_pkg::ADDR_MAP_B, 8'hFD);
    uart_irq <= 4'h5;
    watchdog_source <= 1'b0;
    mgmt_sig <= 1'b0;
    host(1, 16'h0000);
    wr(sirq_pkg::ADDR_CFG, 8'h80);
    for (int i = 3; i < 8; i++) begin
      start_lo <= 3'(i);
      host(1, 16'hA024);
    end
    chk_pin(mgmt_pin, 2'b01);
    wr(sirq_pkg::ADDR_SMI_EN, 8'h40);
    host(1, 16'hA024);
    chk_pin(mgmt_pin, 2'b00);
    wr(sirq_pkg::ADDR_SMI_EN, 8'h80);
    stop_lo <= 2'h2;
    host(1, 16'hA020);
    repeat (4) @(posedge clk_sys);
    rd(sirq_pkg::ADDR_STATUS, 8'h01);
    t0 = cycles;
    stop_lo <= 2'h3;
    uart_irq <= 4'h7;
    wait_for(t0 + 1);
    chk16(lo_seen, 16'h8020);
    repeat (4) @(posedge clk_sys);
    rd(sirq_pkg::ADDR_STATUS, 8'h00);
    uart_irq <= 4'h5;
    repeat (100) @(posedge clk_sys);
    chk_n(cycles, t0 + 1);
    host(2, 16'hA020);
    chk_n(errs, 0);
    print_verdict();
  end
endmodule : serial_irq_slave_tb

/* bench/sirq_host_model.sv */
`timescale 1ns/100ps
module sirq_host_model (
  input  wire logic                clk_sys,
  input  wire logic                reset_n,
  input  wire logic                go,
  input  wire logic [2:0]          start_lo,
  input  wire logic [1:0]          stop_lo,
  input  wire sirq_pkg::sirq_pin_t dev,
  output logic                     line,
  output logic [15:0]              lo_seen,
  output int                       cycles,
  output int                       errs
);
  logic h_oe;
  logic h_out;
  logic quiet;
  logic lo;
  int   k;

  // The wire has a pull-up, so a released line reads high.
  assign line = dev.oe ? dev.out : (h_oe ? h_out : 1'b1);

  task automatic tick;
    @(posedge clk_sys);
    #1;
    if (dev.oe && h_oe) errs++;
  endtask : tick

  task automatic drive(input logic v, input int n);
    h_oe = 1'b1;
    h_out = v;
    repeat (n) tick();
  endtask : drive

  task automatic run(input logic by_dev);
    lo_seen = '0;
    lo = 1'b0;
    if (by_dev) begin
      tick();
      if (dev.oe) errs++;
    end
    drive(1'b0, int'(start_lo) + (by_dev ? 0 : 1));
    drive(1'b1, 1);
    h_oe = 1'b0;
    for (int c = 1; c < 50; c++) begin
      k = c % 3;
      if (k == 2) begin
        lo = !line;
        lo_seen[c/3] = lo;
      end
      if (dev.oe !== (k != 1 && lo) || (k == 0 && lo && dev.out !== 1'b1))
        errs++;
      tick();
    end
    drive(1'b0, int'(stop_lo));
    drive(1'b1, 1);
    h_oe = 1'b0;
    quiet = (stop_lo == 2'h2);
    cycles++;
  endtask : run

  initial begin
    h_oe = 1'b0;
    h_out = 1'b1;
    quiet = 1'b0;
    cycles = 0;
    errs = 0;
    lo_seen = '0;
    lo = 1'b0;
    forever begin
      tick();
      if (!reset_n) quiet = 1'b0;
      else if (go) run(1'b0);
      else if (dev.oe) begin
        if (!quiet || dev.out) errs++;
        run(1'b1);
      end
    end
  end
endmodule : sirq_host_model

/* verilog/sirq_pkg.sv */
// Function
// RULE_01 - Quiet mode idle: device pulls line low one clock, then releases.
// RULE_02 - No Start Frame while a cycle is active, Start to Stop.
// RULE_03 - Host extends start low three to seven clocks, drives high, releases.
// RULE_04 - Any source level change triggers a Quiet Start unless cycle carries it.
// RULE_05 - Continuous mode: only host starts frames; device stays passive.
// RULE_06 - Mode changes only at Stop Frame; reset gives Continuous mode. The code also drops to Continuous whenever enable bit D7 is clear.
// RULE_07 - Stop low two clocks means Quiet, three means Continuous.
// RULE_08 - Data frames count from Start rising edge; three clocks each.
// RULE_09 - Sample phase: drive low only when slot level is low.
// RULE_10 - Recovery phase: drive high only after driving low in Sample.
// RULE_11 - Turn-around phase: release the line.
// RULE_12 - Report low level every cycle, whoever started it.
// RULE_13 - Slot n samples 3n-1 clocks after the Start rising edge.
// RULE_14 - Slot 3 shared by IRQ2 and management interrupt.
// RULE_15 - IRQ13 in slot 14 selectable by serial ports and watchdog.
// RULE_16 - Enable bit 6 puts SMI in slot; bit 7 drives its pin.
// RULE_17 - Interface inactive unless config enable bit D7 set.
// RULE_18 - Only four serial ports and watchdog map into the stream.
// RULE_19 - Stop Frame may hold idle clocks; next Start may follow at once.
// RULE_20 - Only host makes Stop Frame, after all data frames.
// RULE_21 - Under bus reset line is released and mode is Continuous idle.
// RULE_22 - Line driven and sampled on the rising clock edge.
// RULE_23 - Per-slot level vector from slot maps; zero unmapped; low wins.
package sirq_pkg;

  localparam logic [2:0] ADDR_CFG    = 3'h0;
  localparam logic [2:0] ADDR_MAP_A  = 3'h1;
  localparam logic [2:0] ADDR_MAP_B  = 3'h2;
  localparam logic [2:0] ADDR_MAP_W  = 3'h3;
  localparam logic [2:0] ADDR_SMI_EN = 3'h4;
  localparam logic [2:0] ADDR_STATUS = 3'h5;

  localparam int CFG_EN_BIT   = 7;
  localparam int SMI_SLOT_BIT = 6;
  localparam int SMI_PIN_BIT  = 7;
  localparam logic [3:0] SMI_IRQ = 4'h2;

  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] MAP_RESET = 8'h00;
  localparam logic [7:0] SMI_RESET = 8'h00;

  // The synced rise is acted on three clocks after the pin rose.
  localparam logic [6:0] CNT_SYNC_LAT  = 7'h03;
  localparam logic [6:0] CNT_FIRST    = 7'h02;
  localparam logic [6:0] CNT_LAST     = 7'h31;
  localparam logic [6:0] CNT_MAX      = 7'h7F;
  localparam logic [6:0] FRAME_CLOCKS = 7'h03;
  localparam logic [2:0] STOP_QUIET   = 3'h2;
  localparam logic [2:0] STOP_CONT    = 3'h3;
  localparam logic [1:0] START_GAP    = 2'h2;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_KICK  = 4'b0010,
    ST_START = 4'b0100,
    ST_DATA  = 4'b1000
  } sirq_state_t;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } sirq_bus_t;

  typedef struct packed {
    logic out;
    logic oe;
  } sirq_pin_t;

endpackage : sirq_pkg

/* verilog/sirq_slave.sv */
`timescale 1ns/100ps
module sirq_slave (
  input  wire logic               clk_sys,
  input  wire logic               reset_n,
  input  wire sirq_pkg::sirq_bus_t bus,
  output logic [7:0]              rdata,
  input  wire logic [3:0]         uart_irq,
  input  wire logic               watchdog_source,
  input  wire logic               mgmt_interrupt_signal,
  input  wire logic               sirq_in,
  output sirq_pkg::sirq_pin_t     sirq_pin,
  output sirq_pkg::sirq_pin_t     mgmt_interrupt_pin
);

  function automatic logic [3:0] irq_of(input logic [6:0] c);
    logic [6:0] r;
    r = (c - sirq_pkg::CNT_FIRST) / sirq_pkg::FRAME_CLOCKS;
    return r[3:0];
  endfunction : irq_of

  function automatic logic [1:0] phase_of(input logic [6:0] c);
    logic [6:0] r;
    r = (c - sirq_pkg::CNT_FIRST) % sirq_pkg::FRAME_CLOCKS;
    return r[1:0];
  endfunction : phase_of

  function automatic logic in_frames(input logic [6:0] c);
    return (c >= sirq_pkg::CNT_FIRST) && (c <= sirq_pkg::CNT_LAST);
  endfunction : in_frames

  // Registers.
  logic [7:0] cfg_q;
  logic [7:0] map_a_q;
  logic [7:0] map_b_q;
  logic [7:0] map_w_q;
  logic [7:0] smi_en_q;
  logic [7:0] rdata_q;

  // Protocol state.
  sirq_pkg::sirq_state_t st_q;
  sirq_pkg::sirq_state_t st_d;
  logic        s1_q;
  logic        s2_q;
  logic        prev_q;
  logic [6:0]  cnt_q;
  logic [6:0]  cnt_d;
  logic [2:0]  low_q;
  logic [1:0]  gap_q;
  logic        quiet_q;
  logic [15:0] sent_q;
  logic        out_q;
  logic        oe_q;
  logic        out_d;
  logic        oe_d;
  logic        smi_oe_q;

  wire        en       = cfg_q[sirq_pkg::CFG_EN_BIT];
  wire        line     = s2_q;
  wire        rise     = s2_q & ~prev_q;
  wire        stop_q2  = rise && (low_q == sirq_pkg::STOP_QUIET);
  wire        stop_q3  = rise && (low_q == sirq_pkg::STOP_CONT);
  wire        stop_hit = (st_q == sirq_pkg::ST_DATA) && (stop_q2 || stop_q3);

  // Slot level vector indexed by IRQ number.
  function automatic logic [15:0] level_vec(
    input logic [3:0] src,
    input logic       wd,
    input logic       smi,
    input logic [7:0] ma,
    input logic [7:0] mb,
    input logic [7:0] mw,
    input logic       smi_on
  );
    logic [15:0] v;
    logic [3:0]  m [5];
    logic [4:0]  lv;
    v = 16'hFFFF;
    m[0] = ma[3:0];
    m[1] = ma[7:4];
    m[2] = mb[3:0];
    m[3] = mb[7:4];
    m[4] = mw[3:0];
    lv = {wd, src};
    for (int s = 0; s < 5; s++) begin
      if (m[s] != 4'h0) begin
        v[m[s]] = v[m[s]] & lv[s]; // RULE_23 RULE_18 RULE_15
      end
    end
    if (smi_on) begin
      v[sirq_pkg::SMI_IRQ] = v[sirq_pkg::SMI_IRQ] & smi; // RULE_14 RULE_16
    end
    return v;
  endfunction : level_vec

  wire [15:0] lvl = level_vec(uart_irq, watchdog_source,
                              mgmt_interrupt_signal, map_a_q, map_b_q,
                              map_w_q, smi_en_q[sirq_pkg::SMI_SLOT_BIT]);
  wire        pending = |(lvl ^ sent_q);

  wire        kick_go  = en && quiet_q && pending && line &&
                         (gap_q >= sirq_pkg::START_GAP); // RULE_01 RULE_04

  // Next state.
  always_comb begin
    st_d  = st_q;
    cnt_d = cnt_q;
    case (st_q)
      sirq_pkg::ST_IDLE: begin
        if (!line) begin
          st_d = sirq_pkg::ST_START;
        end else if (kick_go) begin
          st_d = sirq_pkg::ST_KICK; // RULE_01 RULE_02
        end
      end
      sirq_pkg::ST_KICK: begin
        if (!line) begin
          st_d = sirq_pkg::ST_START;
        end
      end
      sirq_pkg::ST_START: begin
        if (rise) begin
          st_d  = sirq_pkg::ST_DATA;
          cnt_d = sirq_pkg::CNT_SYNC_LAT; // RULE_08
        end
      end
      sirq_pkg::ST_DATA: begin
        if (stop_hit) begin
          st_d = sirq_pkg::ST_IDLE; // RULE_20 RULE_19
        end else if (cnt_q != sirq_pkg::CNT_MAX) begin
          cnt_d = cnt_q + 7'h01;
        end
      end
      default: begin
        st_d = sirq_pkg::ST_IDLE;
      end
    endcase
    if (!en) begin
      st_d = sirq_pkg::ST_IDLE; // RULE_17
    end
  end

  wire [3:0] irq_d   = irq_of(cnt_d);
  wire [1:0] ph_d    = phase_of(cnt_d);
  wire       data_d  = (st_d == sirq_pkg::ST_DATA) && in_frames(cnt_d);
  wire       samp_d  = data_d && (ph_d == 2'h0) && (irq_d != 4'h0);
  wire       drv_lo  = samp_d && !lvl[irq_d]; // RULE_09 RULE_12 RULE_13
  wire       drv_hi  = data_d && (ph_d == 2'h1) && oe_q && !out_q; // RULE_10
  wire       kick_d  = (st_q == sirq_pkg::ST_IDLE) &&
                       (st_d == sirq_pkg::ST_KICK);

  // Turn-around and everything else leave the line released.
  assign oe_d  = kick_d || drv_lo || drv_hi; // RULE_11
  assign out_d = drv_hi;

  // Pin synchroniser; the first stage feeds only the second.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s1_q   <= 1'b1;
      s2_q   <= 1'b1;
      prev_q <= 1'b1;
    end else begin
      s1_q   <= sirq_in; // RULE_22
      s2_q   <= s1_q;
      prev_q <= s2_q;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st_q  <= sirq_pkg::ST_IDLE; // RULE_21
      cnt_q <= 7'h00;
      out_q <= 1'b1;
      oe_q  <= 1'b0;
    end else begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
      out_q <= out_d;
      oe_q  <= oe_d;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      low_q <= 3'h0;
    end else if (line) begin
      low_q <= 3'h0;
    end else if (low_q != 3'h7) begin
      low_q <= low_q + 3'h1; // RULE_07
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      gap_q <= 2'h0;
    end else if (st_q != sirq_pkg::ST_IDLE || !line) begin
      gap_q <= 2'h0;
    end else if (gap_q != 2'h3) begin
      gap_q <= gap_q + 2'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      quiet_q <= 1'b0; // RULE_06 RULE_21
    end else if (!en) begin
      quiet_q <= 1'b0;
    end else if (stop_hit) begin
      quiet_q <= stop_q2; // RULE_06 RULE_07
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sent_q <= 16'hFFFF;
    end else if (samp_d) begin
      sent_q[irq_d] <= lvl[irq_d]; // RULE_04
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      smi_oe_q <= 1'b0;
    end else begin
      smi_oe_q <= smi_en_q[sirq_pkg::SMI_PIN_BIT] &
                  ~mgmt_interrupt_signal; // RULE_16
    end
  end

  // Register port.
  wire wr_cfg = bus.wr && (bus.addr == sirq_pkg::ADDR_CFG);
  wire wr_ma  = bus.wr && (bus.addr == sirq_pkg::ADDR_MAP_A);
  wire wr_mb  = bus.wr && (bus.addr == sirq_pkg::ADDR_MAP_B);
  wire wr_mw  = bus.wr && (bus.addr == sirq_pkg::ADDR_MAP_W);
  wire wr_smi = bus.wr && (bus.addr == sirq_pkg::ADDR_SMI_EN);
  wire [7:0] status = {5'h00, pending,
                       st_q != sirq_pkg::ST_IDLE, quiet_q};
  wire [7:0] rd_mux =
    (bus.addr == sirq_pkg::ADDR_CFG)    ? cfg_q    :
    (bus.addr == sirq_pkg::ADDR_MAP_A)  ? map_a_q  :
    (bus.addr == sirq_pkg::ADDR_MAP_B)  ? map_b_q  :
    (bus.addr == sirq_pkg::ADDR_MAP_W)  ? {4'h0, map_w_q[3:0]} :
    (bus.addr == sirq_pkg::ADDR_SMI_EN) ? smi_en_q :
    (bus.addr == sirq_pkg::ADDR_STATUS) ? status   : 8'h00;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cfg_q    <= sirq_pkg::CFG_RESET;
      map_a_q  <= sirq_pkg::MAP_RESET;
      map_b_q  <= sirq_pkg::MAP_RESET;
      map_w_q  <= sirq_pkg::MAP_RESET;
      smi_en_q <= sirq_pkg::SMI_RESET;
    end else begin
      if (wr_cfg) cfg_q <= {bus.wdata[7], 7'h00};
      if (wr_ma) map_a_q <= bus.wdata;
      if (wr_mb) map_b_q <= bus.wdata;
      if (wr_mw) map_w_q <= {4'h0, bus.wdata[3:0]};
      if (wr_smi) smi_en_q <= {bus.wdata[7:6], 6'h00};
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= bus.rd ? rd_mux : 8'h00;
    end
  end

  assign rdata                  = rdata_q;
  assign sirq_pin.out           = out_q;
  assign sirq_pin.oe            = oe_q;
  assign mgmt_interrupt_pin.out = 1'b0;
  assign mgmt_interrupt_pin.oe  = smi_oe_q;

  // Checks.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  kick_pulse_a: assert property ( // RULE_01
    (st_q == sirq_pkg::ST_KICK && $past(st_q) == sirq_pkg::ST_IDLE)
      |-> oe_q && !out_q ##1 !oe_q)
    else $error("start pulse is not one low clock");

  no_kick_busy_a: assert property ( // RULE_02
    (st_q == sirq_pkg::ST_DATA || st_q == sirq_pkg::ST_START)
      |=> st_q != sirq_pkg::ST_KICK)
    else $error("start frame begun during active cycle");

  cont_passive_a: assert property ( // RULE_05
    (!quiet_q && st_q == sirq_pkg::ST_IDLE) |=> st_q != sirq_pkg::ST_KICK)
    else $error("device started frame in continuous mode");

  mode_at_stop_a: assert property ( // RULE_06
    ($changed(quiet_q) && $past(en) && en)
      |-> $past(st_q) == sirq_pkg::ST_DATA && st_q == sirq_pkg::ST_IDLE)
    else $error("mode changed outside stop frame");

  stop_width_a: assert property ( // RULE_07
    (st_q == sirq_pkg::ST_DATA && en && rise && low_q == 3'h2)
      |=> quiet_q && st_q == sirq_pkg::ST_IDLE)
    else $error("two clock stop did not select quiet");

  recovery_a: assert property ( // RULE_10
    (oe_q && out_q) |-> $past(oe_q) && !$past(out_q))
    else $error("line driven high without prior low sample");

  turnaround_a: assert property ( // RULE_11
    (st_q == sirq_pkg::ST_DATA && oe_q && !out_q && en)
      |=> (oe_q && out_q) ##1 !oe_q)
    else $error("recovery or turn-around phase wrong");

  sample_slot_a: assert property ( // RULE_13
    (st_q == sirq_pkg::ST_DATA && oe_q && !out_q)
      |-> phase_of(cnt_q) == 2'h0 && cnt_q >= 7'h05 && cnt_q <= 7'h2F)
    else $error("sample drive outside a slot sample clock");

  disabled_a: assert property ( // RULE_17
    !en |=> !oe_q && st_q == sirq_pkg::ST_IDLE)
    else $error("line driven while interface disabled");

  kick_cov: cover property (st_q == sirq_pkg::ST_KICK ##1 !oe_q);
  slot_cov: cover property (st_q == sirq_pkg::ST_DATA && oe_q && !out_q);
  quiet_cov: cover property (stop_hit && stop_q2);

endmodule : sirq_slave
